//--- design/sdpi_pkg.sv
// sdpi_pkg: constants, field layout and carrier types of the serial-port dma pointer block.
// assumes an 8-bit register port and a 12-bit byte-addressed data ram.
package sdpi_pkg;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL_A  = 4'h0;
  localparam logic [3:0] OFS_CTRL_B  = 4'h1;
  localparam logic [3:0] OFS_TX_HIGH = 4'h2;
  localparam logic [3:0] OFS_TX_LOW  = 4'h3;
  localparam logic [3:0] OFS_RX_HIGH = 4'h4;
  localparam logic [3:0] OFS_RX_LOW  = 4'h5;
  localparam logic [3:0] OFS_BC_HIGH = 4'h6;
  localparam logic [3:0] OFS_BC_LOW  = 4'h7;
  localparam logic [3:0] OFS_STATUS  = 4'h8;

  // --------------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------------
  localparam int unsigned CA_ENABLE  = 0;
  localparam int unsigned CA_DLY_IRQ = 1;
  localparam int unsigned CA_DUP_LO  = 2;
  localparam int unsigned CA_DUP_HI  = 3;
  localparam int unsigned CA_RX_INC  = 4;
  localparam int unsigned CA_TX_INC  = 5;
  localparam int unsigned CA_SS_LO   = 6;
  localparam int unsigned CA_SS_HI   = 7;
  localparam int unsigned CB_WM_LO   = 0;
  localparam int unsigned CB_WM_HI   = 3;
  localparam int unsigned ST_FLAG    = 0;
  localparam int unsigned ST_ENABLE  = 1;
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  localparam int unsigned PTR_W      = 12;
  localparam int unsigned PTR_HIGH_W = 4;
  localparam int unsigned BC_W       = 10;
  localparam int unsigned BC_HIGH_W  = 2;
  localparam int unsigned REM_W      = 11;

  // duplex field codes
  localparam logic [1:0] DUP_FULL    = 2'h2;
  localparam logic [1:0] DUP_TX_ONLY = 2'h1;
  localparam logic [1:0] DUP_RX_ONLY = 2'h0;

  // the top two 256-byte banks of data ram hold special function registers
  localparam logic [2:0] SFR_BANK_TOP = 3'h7;

  // remaining-byte level per watermark code, code 0 is completion only
  localparam logic [15:0][REM_W-1:0] WM_LEVELS = {
    11'h240, 11'h200, 11'h1c0, 11'h180, 11'h140, 11'h100, 11'h0c0, 11'h080,
    11'h043, 11'h020, 11'h010, 11'h008, 11'h004, 11'h002, 11'h001, 11'h000};

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDPI_TX_EMPTY = 2'h0,
    SDPI_TX_REQ   = 2'h1,
    SDPI_TX_WAIT  = 2'h3,
    SDPI_TX_FULL  = 2'h2
  } sdpi_tx_e;

  typedef struct packed {
    logic              rd;
    logic [PTR_W-1:0]  addr;
  } sdpi_mem_rd_s;

  typedef struct packed {
    logic              wr;
    logic [PTR_W-1:0]  addr;
    logic [7:0]        data;
  } sdpi_mem_wr_s;

  typedef struct packed {
    logic [7:0]        ctrl_a;
    logic [7:0]        ctrl_b;
    logic [PTR_W-1:0]  tx_ptr;
    logic [PTR_W-1:0]  rx_ptr;
    logic [BC_W-1:0]   count;
    logic              flag;
    logic              armed;
    sdpi_tx_e          tx_st;
    logic [7:0]        tx_byte;
    logic              tx_valid;
    sdpi_mem_rd_s      mrd;
    sdpi_mem_wr_s      mwr;
    logic              start;
    logic [7:0]        rdata;
  } sdpi_state_s;

endpackage

//--- design/sdpi_top.sv
// sdpi_top: pointer, byte-count and interrupt-flag logic of the serial-port dma engine.
// assumes the shifter and data ram share clock_in; ram read data arrive the cycle after
// the read strobe; byte_done_in pulses once per byte moved by the shifter.
`timescale 1ns/1ps
`default_nettype none

module sdpi_top (
  input  wire logic                         clock_in,
  input  wire logic                         rst_in,
  input  wire logic [sdpi_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [7:0]                   reg_wdata_in,
  input  wire logic                         reg_write_in,
  input  wire logic                         reg_read_in,
  output logic      [7:0]                   reg_rdata_out,
  input  wire logic                         master_mode_in,
  input  wire logic                         byte_done_in,
  input  wire logic [7:0]                   rx_byte_in,
  output logic      [7:0]                   tx_byte_out,
  output logic                              tx_valid_out,
  output logic                              start_out,
  output logic                              xfer_active_out,
  output logic                              serial_irq_flag_out,
  output sdpi_pkg::sdpi_mem_rd_s            mem_rd_out,
  input  wire logic [7:0]                   mem_rd_data_in,
  output sdpi_pkg::sdpi_mem_wr_s            mem_wr_out
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  sdpi_pkg::sdpi_state_s state_r;
  sdpi_pkg::sdpi_state_s state_nxt;

  logic                             enable;
  logic [1:0]                       duplex;
  logic                             uses_tx;
  logic                             uses_rx;
  logic [sdpi_pkg::REM_W-1:0]       remaining;
  logic [sdpi_pkg::REM_W-1:0]       level;
  logic [sdpi_pkg::REM_W-1:0]       new_level;
  logic                             wr_ctrl_a;
  logic                             wr_ctrl_b;
  logic                             last_byte;
  logic                             flag_set;
  logic                             flag_clr;
  logic                             tx_sfr;
  logic                             rx_sfr;

  assign enable    = state_r.ctrl_a[sdpi_pkg::CA_ENABLE];
  assign duplex    = state_r.ctrl_a[sdpi_pkg::CA_DUP_HI:sdpi_pkg::CA_DUP_LO];
  // a reserved duplex code moves both pointers like full duplex
  assign uses_tx   = (duplex != sdpi_pkg::DUP_RX_ONLY);
  assign uses_rx   = (duplex != sdpi_pkg::DUP_TX_ONLY);
  assign remaining = sdpi_pkg::REM_W'(state_r.count) + sdpi_pkg::REM_W'(1);
  assign level     =
    sdpi_pkg::WM_LEVELS[state_r.ctrl_b[sdpi_pkg::CB_WM_HI:sdpi_pkg::CB_WM_LO]];
  assign new_level = sdpi_pkg::WM_LEVELS[reg_wdata_in[sdpi_pkg::CB_WM_HI:sdpi_pkg::CB_WM_LO]];
  assign wr_ctrl_a = reg_write_in && (reg_addr_in == sdpi_pkg::OFS_CTRL_A);
  assign wr_ctrl_b = reg_write_in && (reg_addr_in == sdpi_pkg::OFS_CTRL_B);
  assign last_byte = enable && byte_done_in && (state_r.count == '0);
  assign tx_sfr    = (state_r.tx_ptr[sdpi_pkg::PTR_W-1 -: 3] == sdpi_pkg::SFR_BANK_TOP);
  assign rx_sfr    = (state_r.rx_ptr[sdpi_pkg::PTR_W-1 -: 3] == sdpi_pkg::SFR_BANK_TOP);
  assign flag_clr  = reg_write_in && (reg_addr_in == sdpi_pkg::OFS_STATUS)
                     && reg_wdata_in[sdpi_pkg::ST_FLAG];

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt       = state_r;
    state_nxt.start = 1'b0;
    state_nxt.mrd.rd = 1'b0;
    state_nxt.mwr.wr = 1'b0;
    flag_set        = 1'b0;

    // register writes
    if (reg_write_in) begin
      unique case (reg_addr_in)
        sdpi_pkg::OFS_CTRL_A: begin
          state_nxt.ctrl_a = reg_wdata_in;
          // slave-select drive by the engine forces the delay interrupt off
          if (reg_wdata_in[sdpi_pkg::CA_SS_HI:sdpi_pkg::CA_SS_LO] != 2'h0) begin
            state_nxt.ctrl_a[sdpi_pkg::CA_DLY_IRQ] = 1'b0;
          end
        end
        sdpi_pkg::OFS_CTRL_B: state_nxt.ctrl_b = reg_wdata_in;
        sdpi_pkg::OFS_TX_HIGH:
          state_nxt.tx_ptr[sdpi_pkg::PTR_W-1 -: sdpi_pkg::PTR_HIGH_W] =
            reg_wdata_in[sdpi_pkg::PTR_HIGH_W-1:0];
        sdpi_pkg::OFS_TX_LOW:  state_nxt.tx_ptr[7:0] = reg_wdata_in;
        sdpi_pkg::OFS_RX_HIGH:
          state_nxt.rx_ptr[sdpi_pkg::PTR_W-1 -: sdpi_pkg::PTR_HIGH_W] =
            reg_wdata_in[sdpi_pkg::PTR_HIGH_W-1:0];
        sdpi_pkg::OFS_RX_LOW:  state_nxt.rx_ptr[7:0] = reg_wdata_in;
        sdpi_pkg::OFS_BC_HIGH:
          state_nxt.count[sdpi_pkg::BC_W-1 -: sdpi_pkg::BC_HIGH_W] =
            reg_wdata_in[sdpi_pkg::BC_HIGH_W-1:0];
        sdpi_pkg::OFS_BC_LOW:  state_nxt.count[7:0] = reg_wdata_in;
        default: ;
      endcase
    end

    // start of a transaction: master starts the shifter, slave only waits
    if (wr_ctrl_a && !enable && reg_wdata_in[sdpi_pkg::CA_ENABLE]) begin
      state_nxt.start = master_mode_in;
      state_nxt.armed = 1'b1;
    end

    // a watermark raised above what is left rearms the flag
    if (wr_ctrl_b && enable && (new_level > remaining)) begin
      state_nxt.armed = 1'b1;
    end

    // per-byte progress
    if (byte_done_in) begin
      if (!enable) begin
        flag_set = 1'b1;
      end else begin
        if (uses_rx && !rx_sfr) begin
          state_nxt.mwr.wr   = 1'b1;
          state_nxt.mwr.addr = state_r.rx_ptr;
          state_nxt.mwr.data = rx_byte_in;
        end
        if (uses_rx && state_r.ctrl_a[sdpi_pkg::CA_RX_INC]) begin
          state_nxt.rx_ptr = state_r.rx_ptr + sdpi_pkg::PTR_W'(1);
        end
        if (uses_tx && state_r.ctrl_a[sdpi_pkg::CA_TX_INC]) begin
          state_nxt.tx_ptr = state_r.tx_ptr + sdpi_pkg::PTR_W'(1);
        end
        if (last_byte) begin
          state_nxt.ctrl_a[sdpi_pkg::CA_ENABLE] = 1'b0;
          state_nxt.armed = 1'b0;
          flag_set        = 1'b1;
        end else begin
          state_nxt.count = state_r.count - sdpi_pkg::BC_W'(1);
        end
      end
    end

    // watermark: fires once when the remaining count reaches the level
    if (enable && state_r.armed && !last_byte && (level != '0)) begin
      if (remaining <= level) begin
        flag_set        = 1'b1;
        state_nxt.armed = 1'b0;
      end
    end

    // set wins over a clear in the same cycle; nothing else clears the flag
    state_nxt.flag = (state_r.flag && !flag_clr) || flag_set;

    // transmit byte fetch
    unique case (state_r.tx_st)
      sdpi_pkg::SDPI_TX_EMPTY: begin
        if (enable && uses_tx && !last_byte) begin
          if (tx_sfr) begin
            // register banks are not readable, the shifter sends zero
            state_nxt.tx_byte  = 8'h00;
            state_nxt.tx_valid = 1'b1;
            state_nxt.tx_st    = sdpi_pkg::SDPI_TX_FULL;
          end else begin
            state_nxt.mrd.rd   = 1'b1;
            state_nxt.mrd.addr = state_r.tx_ptr;
            state_nxt.tx_st    = sdpi_pkg::SDPI_TX_REQ;
          end
        end
      end
      sdpi_pkg::SDPI_TX_REQ:  state_nxt.tx_st = sdpi_pkg::SDPI_TX_WAIT;
      sdpi_pkg::SDPI_TX_WAIT: begin
        state_nxt.tx_byte  = mem_rd_data_in;
        state_nxt.tx_valid = 1'b1;
        state_nxt.tx_st    = sdpi_pkg::SDPI_TX_FULL;
      end
      sdpi_pkg::SDPI_TX_FULL: begin
        if (byte_done_in || !enable) begin
          state_nxt.tx_valid = 1'b0;
          state_nxt.tx_st    = sdpi_pkg::SDPI_TX_EMPTY;
        end
      end
    endcase
    // a fetch in flight is dropped when the transaction ends
    if (!enable && (state_r.tx_st != sdpi_pkg::SDPI_TX_EMPTY)) begin
      state_nxt.tx_valid = 1'b0;
      state_nxt.tx_st    = sdpi_pkg::SDPI_TX_EMPTY;
    end

    // read data stand one cycle after the strobe, zero otherwise
    state_nxt.rdata = 8'h00;
    if (reg_read_in) begin
      unique case (reg_addr_in)
        sdpi_pkg::OFS_CTRL_A:  state_nxt.rdata = state_r.ctrl_a;
        sdpi_pkg::OFS_CTRL_B:  state_nxt.rdata = state_r.ctrl_b;
        sdpi_pkg::OFS_TX_HIGH:
          state_nxt.rdata = 8'(state_r.tx_ptr[sdpi_pkg::PTR_W-1 -: sdpi_pkg::PTR_HIGH_W]);
        sdpi_pkg::OFS_TX_LOW:  state_nxt.rdata = state_r.tx_ptr[7:0];
        sdpi_pkg::OFS_RX_HIGH:
          state_nxt.rdata = 8'(state_r.rx_ptr[sdpi_pkg::PTR_W-1 -: sdpi_pkg::PTR_HIGH_W]);
        sdpi_pkg::OFS_RX_LOW:  state_nxt.rdata = state_r.rx_ptr[7:0];
        sdpi_pkg::OFS_BC_HIGH:
          state_nxt.rdata = 8'(state_r.count[sdpi_pkg::BC_W-1 -: sdpi_pkg::BC_HIGH_W]);
        sdpi_pkg::OFS_BC_LOW:  state_nxt.rdata = state_r.count[7:0];
        sdpi_pkg::OFS_STATUS: begin
          state_nxt.rdata[sdpi_pkg::ST_FLAG]   = state_r.flag;
          state_nxt.rdata[sdpi_pkg::ST_ENABLE] = enable;
        end
        default: state_nxt.rdata = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r        <= '0;
      state_r.ctrl_a <= sdpi_pkg::CTRL_RESET;
      state_r.ctrl_b <= sdpi_pkg::CTRL_RESET;
      state_r.tx_st  <= sdpi_pkg::SDPI_TX_EMPTY;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_out       = state_r.rdata;
  assign tx_byte_out         = state_r.tx_byte;
  assign tx_valid_out        = state_r.tx_valid;
  assign start_out           = state_r.start;
  assign xfer_active_out     = enable;
  assign serial_irq_flag_out = state_r.flag;
  assign mem_rd_out          = state_r.mrd;
  assign mem_wr_out          = state_r.mwr;

endmodule // sdpi_top

`default_nettype wire

//--- sim/sdpi_far_model.sv
// sdpi_far_model: behavioural serial shifter and data ram facing the dma block.
// assumes one shared clock; ram answers a read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module sdpi_far_model (
  input  wire logic                   clock_in,
  input  wire logic                   go_in,
  input  wire logic                   need_tx_in,
  input  wire logic [7:0]             gap_in,
  input  wire logic                   tx_valid_in,
  input  wire logic                   active_in,
  input  wire logic [7:0]             tx_byte_in,
  input  wire sdpi_pkg::sdpi_mem_rd_s mem_rd_in,
  input  wire sdpi_pkg::sdpi_mem_wr_s mem_wr_in,
  output logic      [7:0]             mem_data_out,
  output logic                        byte_done_out,
  output logic      [7:0]             rx_byte_out
);
  logic [7:0] ram [0:4095];
  logic [7:0] sent [0:31];
  logic [7:0] seq;
  logic [7:0] wait_cnt;
  initial begin
    mem_data_out = 8'h00;
    byte_done_out = 1'b0;
    rx_byte_out = 8'h00;
    seq = 8'h00;
    wait_cnt = 8'h00;
  end
  // released lines keep moving so a late sample never matches by luck
  always @(posedge clock_in) begin
    mem_data_out <= mem_rd_in.rd ? ram[mem_rd_in.addr] : ~mem_data_out;
    if (mem_wr_in.wr) begin
      ram[mem_wr_in.addr] <= mem_wr_in.data;
    end
    if (byte_done_out) begin
      sent[seq[4:0]] <= tx_byte_in;
      seq <= seq + 8'h01;
      byte_done_out <= 1'b0;
      wait_cnt <= gap_in;
      rx_byte_out <= ~rx_byte_out;
    end else if (go_in && wait_cnt == 8'h00 && (tx_valid_in || !need_tx_in)) begin
      byte_done_out <= 1'b1;
      rx_byte_out <= 8'h40 + seq;
    end else begin
      if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
      if (!active_in) begin
        seq <= 8'h00;
      end
      rx_byte_out <= rx_byte_out + 8'h1b;
    end
  end
endmodule // sdpi_far_model
`default_nettype wire

//--- sim/sdpi_top_sva.sv
// sdpi_top_sva: port-level checks of the serial-port dma pointer block.
// assumes one clock domain, clock_in, with synchronous active-high rst_in.
`timescale 1ns/1ps
`default_nettype none
module sdpi_top_sva (
  input wire logic                          clock_in,
  input wire logic                          rst_in,
  input wire logic [sdpi_pkg::ADDR_W-1:0]   reg_addr_in,
  input wire logic [7:0]                    reg_wdata_in,
  input wire logic                          reg_write_in,
  input wire logic                          master_mode_in,
  input wire logic                          byte_done_in,
  input wire logic                          tx_valid_out,
  input wire logic                          start_out,
  input wire logic                          xfer_active_out,
  input wire logic                          serial_irq_flag_out,
  input wire sdpi_pkg::sdpi_mem_rd_s        mem_rd_out,
  input wire sdpi_pkg::sdpi_mem_wr_s        mem_wr_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic clr_w;
  assign clr_w = reg_write_in && reg_addr_in == sdpi_pkg::OFS_STATUS && reg_wdata_in[0];
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_start_master: assert property ($rose(xfer_active_out) |-> start_out == $past(master_mode_in))
    else $error("start pulse does not follow master mode");
  a_start_rise: assert property (start_out |-> $rose(xfer_active_out))
    else $error("start pulse outside enable rise");
  a_no_sfr_read: assert property (mem_rd_out.rd |-> mem_rd_out.addr[11:9] != sdpi_pkg::SFR_BANK_TOP)
    else $error("ram read in register banks");
  a_no_sfr_write: assert property (mem_wr_out.wr |-> mem_wr_out.addr[11:9] != sdpi_pkg::SFR_BANK_TOP)
    else $error("ram write in register banks");
  a_flag_holds: assert property (serial_irq_flag_out && !clr_w |=> serial_irq_flag_out)
    else $error("flag dropped without clear");
  a_nodma_flag: assert property (byte_done_in && !xfer_active_out |=> serial_irq_flag_out)
    else $error("no flag after idle byte");
  a_done_flag: assert property ($fell(xfer_active_out) && !$past(reg_write_in) |-> serial_irq_flag_out)
    else $error("no flag at completion");
  a_done_byte: assert property ($fell(xfer_active_out) && !$past(reg_write_in) |-> $past(byte_done_in))
    else $error("enable cleared without a final byte");
  a_tx_drop: assert property (byte_done_in && tx_valid_out |=> !tx_valid_out)
    else $error("sent byte still offered");
  c_done: cover property ($fell(xfer_active_out));
  c_start: cover property (start_out);
  c_early_flag: cover property ($rose(serial_irq_flag_out) && xfer_active_out);
endmodule // sdpi_top_sva
`default_nettype wire

//--- sim/spi_dma_pointers_and_irq_bench.sv
// spi_dma_pointers_and_irq_bench: register-level tests of the dma pointer block.
// assumes sdpi_pkg, sdpi_top, sdpi_far_model and sdpi_top_sva are compiled first.
`timescale 1ns/1ps
`default_nettype none
module spi_dma_pointers_and_irq_bench;
  logic clock_in, rst_in, reg_write_in, reg_read_in, master_mode_in, go, need_tx;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, tx_byte_out, rx_byte_in, mem_rd_data_in, gap;
  logic byte_done_in, tx_valid_out, start_out, xfer_active_out, serial_irq_flag_out;
  sdpi_pkg::sdpi_mem_rd_s mem_rd_out;
  sdpi_pkg::sdpi_mem_wr_s mem_wr_out;
  int err_total, num_checks, n;
  sdpi_top DUT (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .master_mode_in(master_mode_in),
    .byte_done_in(byte_done_in), .rx_byte_in(rx_byte_in), .tx_byte_out(tx_byte_out),
    .tx_valid_out(tx_valid_out), .start_out(start_out), .xfer_active_out(xfer_active_out),
    .serial_irq_flag_out(serial_irq_flag_out), .mem_rd_out(mem_rd_out),
    .mem_rd_data_in(mem_rd_data_in), .mem_wr_out(mem_wr_out));
  sdpi_far_model far (.clock_in(clock_in), .go_in(go), .need_tx_in(need_tx), .gap_in(gap),
    .tx_valid_in(tx_valid_out), .active_in(xfer_active_out), .tx_byte_in(tx_byte_out),
    .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out), .mem_data_out(mem_rd_data_in),
    .byte_done_out(byte_done_in), .rx_byte_out(rx_byte_in));
  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] pre(input logic [11:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask
  // config first, enable last, as firmware must
  task automatic xfer(input logic [7:0] ca, input logic [11:0] tx, input logic [11:0] rx,
                      input logic [9:0] cnt, input logic [7:0] cb, input logic g);
    wr(sdpi_pkg::OFS_CTRL_B, cb);
    wr(sdpi_pkg::OFS_TX_HIGH, {4'h0, tx[11:8]});
    wr(sdpi_pkg::OFS_TX_LOW, tx[7:0]);
    wr(sdpi_pkg::OFS_RX_HIGH, {4'h0, rx[11:8]});
    wr(sdpi_pkg::OFS_RX_LOW, rx[7:0]);
    wr(sdpi_pkg::OFS_BC_HIGH, {6'h00, cnt[9:8]});
    wr(sdpi_pkg::OFS_BC_LOW, cnt[7:0]);
    wr(sdpi_pkg::OFS_CTRL_A, ca);
    #1 chk({7'h00, start_out}, {7'h00, master_mode_in});
    go <= g;
  endtask
  // no reload until hardware drops the enable bit
  task automatic wait_idle;
    n = 0;
    while (xfer_active_out !== 1'b0 && n < 3000) begin
      @(posedge clock_in);
      n++;
    end
    chk({7'h00, xfer_active_out}, 8'h00);
    go <= 1'b0;
    repeat (3) @(posedge clock_in);
    rd_chk(sdpi_pkg::OFS_STATUS, 8'h01);
    rd_chk(sdpi_pkg::OFS_BC_LOW, 8'h00);
    rd_chk(sdpi_pkg::OFS_BC_HIGH, 8'h00);
    wr(sdpi_pkg::OFS_STATUS, 8'h01);
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    err_total++;
    wrap_up;
  end
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {rst_in, reg_write_in, reg_read_in, master_mode_in, go, need_tx} = 6'h20;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    gap = 8'h02;
    for (int i = 0; i < 4096; i++) far.ram[i] = pre(12'(i));
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 16; a++) rd_chk(4'(a), 8'h00);
    master_mode_in <= 1'b1;
    need_tx <= 1'b1;
    xfer(8'h39, 12'h100, 12'h200, 10'h003, 8'h00, 1'b1);
    wait_idle;
    for (int i = 0; i < 4; i++) begin
      chk(far.sent[i], pre(12'h100 + 12'(i)));
      chk(far.ram[12'h200 + 12'(i)], 8'h40 + 8'(i));
    end
    chk(far.ram[12'h204], pre(12'h204));
    xfer(8'h05, 12'h300, 12'h600, 10'h001, 8'h00, 1'b1);
    wait_idle;
    chk(far.sent[0], pre(12'h300));
    chk(far.sent[1], pre(12'h300));
    chk(far.ram[12'h600], pre(12'h600));
    xfer(8'h25, 12'hdff, 12'h000, 10'h001, 8'h00, 1'b1);
    wait_idle;
    chk(far.sent[0], pre(12'hdff));
    chk(far.sent[1], 8'h00);
    need_tx <= 1'b0;
    xfer(8'h11, 12'h000, 12'hdfe, 10'h002, 8'h00, 1'b1);
    wait_idle;
    chk(far.ram[12'hdff], 8'h41);
    chk(far.ram[12'he00], pre(12'he00));
    master_mode_in <= 1'b0;
    gap <= 8'h14;
    xfer(8'h11, 12'h000, 12'h500, 10'h011, 8'h05, 1'b0);
    repeat (3) @(posedge clock_in);
    rd_chk(sdpi_pkg::OFS_STATUS, 8'h02);
    go <= 1'b1;
    n = 0;
    while (serial_irq_flag_out !== 1'b1 && n < 2000) begin
      @(posedge clock_in);
      n++;
    end
    chk({7'h00, serial_irq_flag_out}, 8'h01);
    rd_chk(sdpi_pkg::OFS_BC_LOW, 8'h0f);
    wr(sdpi_pkg::OFS_STATUS, 8'h01);
    rd_chk(sdpi_pkg::OFS_STATUS, 8'h02);
    wr(sdpi_pkg::OFS_CTRL_B, 8'h0f);
    rd_chk(sdpi_pkg::OFS_STATUS, 8'h03);
    wr(sdpi_pkg::OFS_STATUS, 8'h01);
    repeat (30) @(posedge clock_in);
    rd_chk(sdpi_pkg::OFS_STATUS, 8'h02);
    wait_idle;
    for (int i = 0; i < 18; i++) chk(far.ram[12'h500 + 12'(i)], 8'h40 + 8'(i));
    gap <= 8'h02;
    repeat (25) @(posedge clock_in);
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
    repeat (3) @(posedge clock_in);
    rd_chk(sdpi_pkg::OFS_STATUS, 8'h01);
    wrap_up;
  end
endmodule // spi_dma_pointers_and_irq_bench
bind sdpi_top sdpi_top_sva u_sva (.clock_in(clock_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .master_mode_in(master_mode_in), .byte_done_in(byte_done_in), .tx_valid_out(tx_valid_out),
  .start_out(start_out), .xfer_active_out(xfer_active_out),
  .serial_irq_flag_out(serial_irq_flag_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out));
`default_nettype wire
